// ### bench/bgrf_asserts.sv
/*
 * Port checker of the banked register file.
 * Assumes it is bound onto bgrf_top, one clock.
 */
module bgrf_asserts
  import bgrf_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire bgrf_pkg::bgrf_rd_req_t rd_req_i,
  input wire bgrf_pkg::bgrf_wr_req_t wr_req_i,
  input wire bgrf_pkg::bgrf_ctl_req_t ctl_req_i,
  input wire bgrf_pkg::bgrf_mode_req_t mode_req_i,
  input wire bgrf_pkg::bgrf_exc_t exc_i,
  input wire bgrf_pkg::bgrf_rd_rsp_t rd_rsp_o,
  input wire logic [31:0] ctl_rdata_o,
  input wire logic ctl_ack_o,
  input wire logic ctl_fault_o,
  input wire logic processor_mode_bit_o,
  input wire logic bank_select_bit_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****
  // Checks
  // ****
  // All checks use the core clock and pause in reset.
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_ACK_ONE: assert property (ctl_req_i.en |=> ctl_ack_o)
    else $error("control ack missing");
  AST_ACK_NONE: assert property (!ctl_req_i.en |=> !ctl_ack_o)
    else $error("control ack without request");
  AST_USER_FAULT: assert property (ctl_req_i.en && !processor_mode_bit_o |=>
    ctl_fault_o && ctl_rdata_o == 32'h0) else $error("user control access not refused");
  AST_PRIV_OK: assert property (ctl_req_i.en && processor_mode_bit_o |=> !ctl_fault_o)
    else $error("privileged control access refused");
  AST_EXC_BITS: assert property (exc_i.take |=> processor_mode_bit_o && bank_select_bit_o)
    else $error("exception did not set mode and bank");
  AST_USER_LOCK: assert property (mode_req_i.en && !exc_i.take && !processor_mode_bit_o |=>
    $stable(processor_mode_bit_o) && $stable(bank_select_bit_o)) else $error("user changed mode bits");
  AST_PRIV_LOAD: assert property (mode_req_i.en && !exc_i.take && processor_mode_bit_o |=>
    processor_mode_bit_o == $past(mode_req_i.md) && bank_select_bit_o == $past(mode_req_i.rb))
    else $error("mode load not applied");
  AST_RD_VALID: assert property (1'b1 |=> rd_rsp_o.valid == $past(rd_req_i.valid))
    else $error("read valid not echoed");
  AST_R0_INDEX: assert property (rd_req_i.valid && rd_req_i.idx_a == 4'h0 |=>
    rd_rsp_o.index_r0 == rd_rsp_o.data_a) else $error("index operand differs from index 0");
  AST_SHARED: assert property (wr_req_i.en && wr_req_i.idx[3] ##2
    rd_req_i.valid && rd_req_i.idx_a == $past(wr_req_i.idx, 2) |=> rd_rsp_o.data_a == $past(wr_req_i.data, 3))
    else $error("shared register lost write");
endmodule

bind bgrf_top bgrf_asserts chk_u (.core_clk_i, .rst_n_i, .rd_req_i, .wr_req_i, .ctl_req_i, .mode_req_i,
  .exc_i, .rd_rsp_o, .ctl_rdata_o, .ctl_ack_o, .ctl_fault_o, .processor_mode_bit_o, .bank_select_bit_o);

// ### bench/bgrf_pipe_model.sv
/*
 * Execution pipeline model: issues reads, writes, control,
 * mode and exception requests. Assumes the bench calls its tasks.
 */
module bgrf_pipe_model
  import bgrf_pkg::*;
(
  input wire logic core_clk_i,
  input wire bgrf_pkg::bgrf_rd_rsp_t rsp_i,
  input wire logic [31:0] ctl_rdata_i,
  input wire logic ctl_ack_i,
  input wire logic ctl_fault_i,
  output bgrf_pkg::bgrf_rd_req_t rd_o,
  output bgrf_pkg::bgrf_wr_req_t wr_o,
  output bgrf_pkg::bgrf_ctl_req_t ctl_o,
  output bgrf_pkg::bgrf_mode_req_t mode_o,
  output bgrf_pkg::bgrf_exc_t exc_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle requests from time zero.
  initial
  begin
    rd_o = '0;
    wr_o = '0;
    ctl_o = '0;
    mode_o = '0;
    exc_o = '0;
  end

  // Each task drives at a falling edge and holds one full cycle.
  // Released data is inverted, except the control target, so stale values are never seen.
  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    @(negedge core_clk_i);
    wr_o <= '{1'b1, i, d};
    @(negedge core_clk_i);
    wr_o <= '{1'b0, ~i, ~d};
  endtask

  task automatic rd(input logic [3:0] i, output logic [31:0] a, output logic [31:0] r0);
    @(negedge core_clk_i);
    rd_o <= '{1'b1, i, ~i};
    @(negedge core_clk_i);
    a = rsp_i.data_a;
    r0 = rsp_i.index_r0;
    rd_o <= '{1'b0, ~i, i};
  endtask

  task automatic ctl(input logic st, input bgrf_ctl_sel_t s, input logic [2:0] b, input logic [31:0] d,
                     output logic [33:0] r);
    @(negedge core_clk_i);
    ctl_o <= '{1'b1, st, s, b, d};
    @(negedge core_clk_i);
    r = {ctl_ack_i, ctl_fault_i, ctl_rdata_i};
    ctl_o <= '{1'b0, ~st, s, ~b, ~d};
  endtask

  task automatic mode(input logic m, input logic b);
    @(negedge core_clk_i);
    mode_o <= '{1'b1, m, b};
    @(negedge core_clk_i);
    mode_o <= '{1'b0, ~m, ~b};
  endtask

  task automatic exc(input logic [31:0] pc);
    @(negedge core_clk_i);
    exc_o <= '{1'b1, 32'h0000_00F0, pc};
    @(negedge core_clk_i);
    exc_o <= '{1'b0, 32'hFFFF_FF0F, ~pc};
  endtask
endmodule

// ### bench/bgrf_top_test.sv
/*
 * Self-checking bench of the banked register file.
 * Assumes the pipeline model and the bound checker.
 */
module bgrf_top_test
  import bgrf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  int bad_count = 0;
  int checks = 0;
  logic [31:0] a, r0;
  logic [33:0] r;
  bgrf_rd_req_t rd_req;
  bgrf_wr_req_t wr_req;
  bgrf_ctl_req_t ctl_req;
  bgrf_mode_req_t mode_req;
  bgrf_exc_t exc;
  bgrf_rd_rsp_t rsp;
  logic [31:0] crd;
  logic ack, flt, md, rb;

  // Free-running 100 MHz clock.
  always #5 core_clk_i = ~core_clk_i;

  bgrf_top dut_u (.core_clk_i, .rst_n_i, .rd_req_i(rd_req), .wr_req_i(wr_req), .ctl_req_i(ctl_req),
    .mode_req_i(mode_req), .exc_i(exc), .rd_rsp_o(rsp), .ctl_rdata_o(crd), .ctl_ack_o(ack),
    .ctl_fault_o(flt), .processor_mode_bit_o(md), .bank_select_bit_o(rb));
  bgrf_pipe_model pipe_u (.core_clk_i, .rsp_i(rsp), .ctl_rdata_i(crd), .ctl_ack_i(ack), .ctl_fault_i(flt),
    .rd_o(rd_req), .wr_o(wr_req), .ctl_o(ctl_req), .mode_o(mode_req), .exc_o(exc));

  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Fills both low banks, reads the visible one, reaches the hidden one.
  task automatic t_banks();
    for (int i = 0; i < 8; i++) pipe_u.wr(4'(i), 32'hB100_0000 + 32'(i));
    pipe_u.mode(1'b1, 1'b0);
    for (int i = 0; i < 8; i++) pipe_u.wr(4'(i), 32'hB000_0000 + 32'(i));
    for (int i = 0; i < 8; i++)
    begin
      pipe_u.rd(4'(i), a, r0);
      chk(a, 32'hB000_0000 + 32'(i));
      pipe_u.ctl(1'b1, BGRF_CTL_BANK, 3'(i), 32'h0, r);
      chk(r[31:0], 32'hB100_0000 + 32'(i));
    end
    pipe_u.ctl(1'b0, BGRF_CTL_BANK, 3'h5, 32'hC5C5_C5C5, r);
    pipe_u.mode(1'b1, 1'b1);
    pipe_u.rd(4'h5, a, r0);
    chk(a, 32'hC5C5_C5C5);
    for (int i = 8; i < 16; i++)
    begin
      pipe_u.wr(4'(i), 32'h5A00_0000 + 32'(i));
      pipe_u.rd(4'(i), a, r0);
      chk(a, 32'h5A00_0000 + 32'(i));
    end
  endtask

  // User mode sees bank zero only and is refused control access.
  task automatic t_user();
    pipe_u.mode(1'b0, 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      pipe_u.rd(4'(i), a, r0);
      chk(a, (i < 8 ? 32'hB000_0000 : 32'h5A00_0000) + 32'(i));
      // The second read port carries the inverted index; its answer still stands here.
      chk(rsp.data_b, (i > 7 ? 32'hB000_0000 : 32'h5A00_0000) + 32'(15 - i));
      chk({31'h0, rsp.valid}, 32'h1);
    end
    pipe_u.wr(4'h3, 32'hD3D3_D3D3);
    pipe_u.ctl(1'b1, BGRF_CTL_BANK, 3'h3, 32'h0, r);
    chk({30'h0, r[33:32]}, 32'h3);
    chk(r[31:0], 32'h0);
    pipe_u.ctl(1'b0, BGRF_CTL_BANK, 3'h3, 32'hEEEE_EEEE, r);
    pipe_u.mode(1'b1, 1'b1);
    chk({31'h0, md}, 32'h0);
  endtask

  // Exception entry switches to bank one and keeps the user bank.
  task automatic t_exc();
    pipe_u.exc(32'h1234_5678);
    chk({30'h0, md, rb}, 32'h3);
    pipe_u.rd(4'h3, a, r0);
    chk(a, 32'hB100_0003);
    pipe_u.rd(4'h0, a, r0);
    chk(r0, 32'hB100_0000);
    pipe_u.ctl(1'b1, BGRF_CTL_BANK, 3'h3, 32'h0, r);
    chk(r[31:0], 32'hD3D3_D3D3);
    pipe_u.ctl(1'b1, BGRF_CTL_SPC, 3'h0, 32'h0, r);
    chk(r[31:0], 32'h1234_5678);
    pipe_u.ctl(1'b1, BGRF_CTL_SGR, 3'h0, 32'h0, r);
    chk(r[31:0], 32'h5A00_000F);
  endtask

  // Loads and stores the privileged control registers, then tries them from user mode.
  task automatic t_ctl();
    pipe_u.ctl(1'b1, BGRF_CTL_SSW, 3'h0, 32'h0, r);
    chk(r[31:0], 32'h0000_00F0);
    chk({30'h0, r[33:32]}, 32'h2);
    pipe_u.ctl(1'b0, BGRF_CTL_DBR, 3'h0, 32'h0DB0_0001, r);
    pipe_u.ctl(1'b0, BGRF_CTL_VBR, 3'h0, 32'h0000_8000, r);
    pipe_u.ctl(1'b1, BGRF_CTL_DBR, 3'h0, 32'h0, r);
    chk(r[31:0], 32'h0DB0_0001);
    pipe_u.ctl(1'b1, BGRF_CTL_VBR, 3'h0, 32'h0, r);
    chk(r[31:0], 32'h0000_8000);
    pipe_u.mode(1'b0, 1'b0);
    pipe_u.ctl(1'b0, BGRF_CTL_DBR, 3'h0, 32'hBAD0_0000, r);
    chk({30'h0, r[33:32]}, 32'h3);
    pipe_u.ctl(1'b1, BGRF_CTL_SPC, 3'h0, 32'h0, r);
    chk({30'h0, r[33:32]}, 32'h3);
    chk(r[31:0], 32'h0);
    pipe_u.exc(32'h0000_4444);
    pipe_u.ctl(1'b1, BGRF_CTL_DBR, 3'h0, 32'h0, r);
    chk(r[31:0], 32'h0DB0_0001);
    pipe_u.ctl(1'b1, BGRF_CTL_SPC, 3'h0, 32'h0, r);
    chk(r[31:0], 32'h0000_4444);
  endtask

  // Mid-run reset: the bank bit returns to one and the vector base to zero.
  task automatic t_reset();
    pipe_u.mode(1'b1, 1'b0);
    @(negedge core_clk_i);
    rst_n_i <= 1'b0;
    @(negedge core_clk_i);
    rst_n_i <= 1'b1;
    chk({30'h0, md, rb}, 32'h3);
    pipe_u.ctl(1'b1, BGRF_CTL_VBR, 3'h0, 32'h0, r);
    chk(r[31:0], 32'h0);
  endtask

  // Main sequence: two reset cycles, then the scenarios.
  initial
  begin
    repeat (2) @(posedge core_clk_i);
    @(negedge core_clk_i);
    rst_n_i <= 1'b1;
    chk({30'h0, md, rb}, 32'h3);
    pipe_u.ctl(1'b1, BGRF_CTL_VBR, 3'h0, 32'h0, r);
    chk(r[31:0], 32'h0);
    t_banks();
    t_user();
    t_exc();
    t_ctl();
    t_reset();
    final_report();
  end

  // Watchdog: the scenarios need well under 1000 cycles.
  initial
  begin
    repeat (3000) @(posedge core_clk_i);
    bad_count++;
    final_report();
  end
endmodule

// ### common/bgrf_map.svh
/*
 * Constants of the banked general register file: physical layout of the
 * twenty-four registers, visible index values and reset values.
 * Assumes it is included by bare name and only holds definitions.
 */
`ifndef BGRF_MAP_SVH
`define BGRF_MAP_SVH

// ****************************************************************
// Physical register layout
// ****************************************************************
`define BGRF_NUM_REGS 24
`define BGRF_PHYS_BANK0 5'h00
`define BGRF_PHYS_BANK1 5'h08
`define BGRF_PHYS_SHARED 5'h10
`define BGRF_PHYS_IDX15 5'h17

// ****************************************************************
// Visible index values
// ****************************************************************
`define BGRF_VIS_IDX0 4'h0
`define BGRF_VIS_HIGH_BIT 3

// ****************************************************************
// Reset values
// ****************************************************************
`define BGRF_MD_RST 1'b1
`define BGRF_RB_RST 1'b1
`define BGRF_VBR_RST 32'h0000_0000

`endif

// ### common/bgrf_pkg.sv
/*
 * Types shared by the banked general register file and its control
 * register bank: request and answer structs and the control target enum.
 * Assumes the map header sits on the include path.
 */
package bgrf_pkg;

  // ****************************************************************
  // Control instruction targets
  // ****************************************************************
  typedef enum logic [2:0] {
    BGRF_CTL_BANK,
    BGRF_CTL_SSW,
    BGRF_CTL_SPC,
    BGRF_CTL_VBR,
    BGRF_CTL_SGR,
    BGRF_CTL_DBR
  } bgrf_ctl_sel_t;

  // ****************************************************************
  // Request and answer structs
  // ****************************************************************
  typedef struct packed {
    logic valid;
    logic [3:0] idx_a;
    logic [3:0] idx_b;
  } bgrf_rd_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] data_a;
    logic [31:0] data_b;
    logic [31:0] index_r0;
  } bgrf_rd_rsp_t;

  typedef struct packed {
    logic en;
    logic [3:0] idx;
    logic [31:0] data;
  } bgrf_wr_req_t;

  typedef struct packed {
    logic en;
    logic store;
    bgrf_ctl_sel_t sel;
    logic [2:0] bidx;
    logic [31:0] data;
  } bgrf_ctl_req_t;

  typedef struct packed {
    logic en;
    logic md;
    logic rb;
  } bgrf_mode_req_t;

  typedef struct packed {
    logic take;
    logic [31:0] status_word;
    logic [31:0] pc;
  } bgrf_exc_t;

endpackage

// ### logic/bgrf_ctl_regs.sv
/*
 * Privileged control register bank: saved status word, saved program
 * counter, vector base, saved index-15 copy and debug base.
 * Assumes the parent only presents writes that passed the privilege check.
 */
module bgrf_ctl_regs
  import bgrf_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire bgrf_pkg::bgrf_ctl_sel_t sel_i,
  input wire logic [31:0] wdata_i,
  input wire bgrf_pkg::bgrf_exc_t exc_i,
  input wire logic [31:0] idx15_i,
  output logic [31:0] rdata_o
);
  import bgrf_pkg::*;
  `include "bgrf_map.svh"

  logic [31:0] ssw_q, ssw_d;
  logic [31:0] spc_q, spc_d;
  logic [31:0] vbr_q, vbr_d;
  logic [31:0] sgr_q, sgr_d;
  logic [31:0] dbr_q, dbr_d;

  // Exception capture takes priority over a software load in the same cycle.
  always_comb
  begin
    ssw_d = ssw_q;
    spc_d = spc_q;
    vbr_d = vbr_q;
    sgr_d = sgr_q;
    dbr_d = dbr_q;
    if (wr_en_i)
    begin
      unique case (sel_i)
        BGRF_CTL_SSW: ssw_d = wdata_i;
        BGRF_CTL_SPC: spc_d = wdata_i;
        BGRF_CTL_VBR: vbr_d = wdata_i;
        BGRF_CTL_SGR: sgr_d = wdata_i;
        BGRF_CTL_DBR: dbr_d = wdata_i;
        default: ;
      endcase
    end
    if (exc_i.take)
    begin
      ssw_d = exc_i.status_word;
      spc_d = exc_i.pc;
      sgr_d = idx15_i;
    end
    if (!rst_n_i)
      vbr_d = `BGRF_VBR_RST;
  end

  // Registers only; the saved copies carry no reset value.
  always_ff @(posedge core_clk_i)
  begin
    ssw_q <= ssw_d;
    spc_q <= spc_d;
    vbr_q <= vbr_d;
    sgr_q <= sgr_d;
    dbr_q <= dbr_d;
  end

  // Read mux for the store-control path.
  always_comb
  begin
    unique case (sel_i)
      BGRF_CTL_SSW: rdata_o = ssw_q;
      BGRF_CTL_SPC: rdata_o = spc_q;
      BGRF_CTL_VBR: rdata_o = vbr_q;
      BGRF_CTL_SGR: rdata_o = sgr_q;
      BGRF_CTL_DBR: rdata_o = dbr_q;
      default: rdata_o = 32'h0000_0000;
    endcase
  end
endmodule

// ### logic/bgrf_top.sv
/*
 * Banked general register file of the CPU core: twenty-four 32-bit
 * registers seen as sixteen, plus mode and bank bits and the privileged
 * control registers reached by the control instructions.
 * Assumes the execution pipeline drives all requests synchronously to
 * core_clk_i and accepts answers one cycle after a request.
 */
module bgrf_top
  import bgrf_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire bgrf_pkg::bgrf_rd_req_t rd_req_i,
  input wire bgrf_pkg::bgrf_wr_req_t wr_req_i,
  input wire bgrf_pkg::bgrf_ctl_req_t ctl_req_i,
  input wire bgrf_pkg::bgrf_mode_req_t mode_req_i,
  input wire bgrf_pkg::bgrf_exc_t exc_i,
  output bgrf_pkg::bgrf_rd_rsp_t rd_rsp_o,
  output logic [31:0] ctl_rdata_o,
  output logic ctl_ack_o,
  output logic ctl_fault_o,
  output logic processor_mode_bit_o,
  output logic bank_select_bit_o
);
  import bgrf_pkg::*;
  `include "bgrf_map.svh"

  // ****************************************************************
  // Index decoding
  // ****************************************************************

  // Maps a visible index to the physical register for the given mode.
  function automatic logic [4:0] vis_to_phys(input logic [3:0] idx, input logic md, input logic rb);
    logic [4:0] base;
    base = `BGRF_PHYS_BANK0;
    if (idx[`BGRF_VIS_HIGH_BIT])
      base = `BGRF_PHYS_SHARED;
    else if (md && rb)
      base = `BGRF_PHYS_BANK1;
    return base + {2'b00, idx[2:0]};
  endfunction

  // Maps a control-instruction bank index to the bank not currently visible in privileged mode.
  function automatic logic [4:0] hidden_to_phys(input logic [2:0] bidx, input logic rb);
    logic [4:0] base;
    base = rb ? `BGRF_PHYS_BANK0 : `BGRF_PHYS_BANK1;
    return base + {2'b00, bidx};
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  logic [31:0] regs_q [`BGRF_NUM_REGS];
  logic [31:0] regs_d [`BGRF_NUM_REGS];
  logic md_q, md_d;
  logic rb_q, rb_d;
  bgrf_rd_rsp_t rsp_q, rsp_d;
  logic [31:0] ctl_rdata_q, ctl_rdata_d;
  logic ctl_ack_q, ctl_ack_d;
  logic ctl_fault_q, ctl_fault_d;
  logic [31:0] ctl_bank_rdata;
  logic [31:0] ctl_priv_rdata;
  logic ctl_priv_wr;
  logic ctl_allowed;
  logic [4:0] wr_phys;
  logic [4:0] rd_phys_a;
  logic [4:0] rd_phys_b;
  logic [4:0] rd_phys_r0;
  logic [4:0] hid_phys;

  // ****************************************************************
  // Combinational selection
  // ****************************************************************

  always_comb
  begin
    wr_phys = vis_to_phys(wr_req_i.idx, md_q, rb_q);
    rd_phys_a = vis_to_phys(rd_req_i.idx_a, md_q, rb_q);
    rd_phys_b = vis_to_phys(rd_req_i.idx_b, md_q, rb_q);
    rd_phys_r0 = vis_to_phys(`BGRF_VIS_IDX0, md_q, rb_q);
    hid_phys = hidden_to_phys(ctl_req_i.bidx, rb_q);
  end

  always_comb
  begin
    ctl_allowed = md_q;
    ctl_priv_wr = ctl_req_i.en && !ctl_req_i.store && ctl_allowed && (ctl_req_i.sel != BGRF_CTL_BANK);
    ctl_bank_rdata = regs_q[hid_phys];
  end

  // ****************************************************************
  // Privileged control registers
  // ****************************************************************

  // Holds the saved copies; captures them when an exception is taken.
  bgrf_ctl_regs u_ctl_regs (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(ctl_priv_wr),
    .sel_i(ctl_req_i.sel),
    .wdata_i(ctl_req_i.data),
    .exc_i(exc_i),
    .idx15_i(regs_q[`BGRF_PHYS_IDX15]),
    .rdata_o(ctl_priv_rdata)
  );

  // ****************************************************************
  // Mode and bank bits
  // ****************************************************************

  // Exception entry wins over a mode load in the same cycle; user loads are dropped.
  always_comb
  begin
    md_d = md_q;
    rb_d = rb_q;
    if (mode_req_i.en && md_q)
    begin
      md_d = mode_req_i.md;
      rb_d = mode_req_i.rb;
    end
    if (exc_i.take)
    begin
      md_d = 1'b1;
      rb_d = 1'b1;
    end
    if (!rst_n_i)
    begin
      md_d = `BGRF_MD_RST;
      rb_d = `BGRF_RB_RST;
    end
  end

  // Registers the mode and bank bits.
  always_ff @(posedge core_clk_i)
  begin
    md_q <= md_d;
    rb_q <= rb_d;
  end

  // ****************************************************************
  // General register array
  // ****************************************************************

  // Pipeline write goes through the visible map, control load to the hidden bank.
  always_comb
  begin
    regs_d = regs_q;
    if (wr_req_i.en)
      regs_d[wr_phys] = wr_req_i.data;
    if (ctl_req_i.en && !ctl_req_i.store && ctl_allowed && (ctl_req_i.sel == BGRF_CTL_BANK))
      regs_d[hid_phys] = ctl_req_i.data;
  end

  always_ff @(posedge core_clk_i)
  begin
    regs_q <= regs_d;
  end

  // ****************************************************************
  // Answers
  // ****************************************************************

  // Read answers show the array before any write of the same cycle.
  always_comb
  begin
    rsp_d.valid = rd_req_i.valid;
    rsp_d.data_a = regs_q[rd_phys_a];
    rsp_d.data_b = regs_q[rd_phys_b];
    rsp_d.index_r0 = regs_q[rd_phys_r0];
    ctl_ack_d = ctl_req_i.en;
    ctl_fault_d = ctl_req_i.en && !ctl_allowed;
    ctl_rdata_d = 32'h0000_0000;
    if (ctl_req_i.en && ctl_req_i.store && ctl_allowed)
      ctl_rdata_d = (ctl_req_i.sel == BGRF_CTL_BANK) ? ctl_bank_rdata : ctl_priv_rdata;
    if (!rst_n_i)
    begin
      rsp_d = '0;
      ctl_ack_d = 1'b0;
      ctl_fault_d = 1'b0;
      ctl_rdata_d = 32'h0000_0000;
    end
  end

  // Registers every answer so all outputs leave from flip-flops.
  always_ff @(posedge core_clk_i)
  begin
    rsp_q <= rsp_d;
    ctl_ack_q <= ctl_ack_d;
    ctl_fault_q <= ctl_fault_d;
    ctl_rdata_q <= ctl_rdata_d;
  end

  // Output assignments.
  assign rd_rsp_o = rsp_q;
  assign ctl_rdata_o = ctl_rdata_q;
  assign ctl_ack_o = ctl_ack_q;
  assign ctl_fault_o = ctl_fault_q;
  assign processor_mode_bit_o = md_q;
  assign bank_select_bit_o = rb_q;
endmodule
